// ==== rtl/dpm_pkg.sv ====
// How it works
// - Sync activity encodes on, standby, suspend and off for the monitor.
// - Horizontal hold bit freezes horizontal sync at misc bit 6 polarity.
// - Vertical hold bit freezes vertical sync at misc bit 7 polarity.
// - Either hold bit powers the palette DAC down, video at blank.
// - Suspend bit gates off video pixel clock and memory clock.
// - In suspend DRAM refresh keeps running and the DAC is powered down.
// - In suspend host gets no display memory or palette access.
// - Access-disable bit blocks host memory and screen refresh, clocks run.
// - Low-power state keeps memory: 3.47 MHz video, 5 refreshes per 4.6 us.
// - In low-power state host gets no display memory or palette access.
// - Writing 04h to memory clock register lowers memory clock to 7.14 MHz.
`default_nettype none

package dpm_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int ACC_W = 17;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MISC_OUTPUT = 8'h04;
  localparam logic [7:0] OFS_CLOCKING_MODE = 8'h08;
  localparam logic [7:0] OFS_CLK0_NUMERATOR = 8'h0c;
  localparam logic [7:0] OFS_CLK0_DENOMINATOR = 8'h10;
  localparam logic [7:0] OFS_VRETRACE_END = 8'h14;
  localparam logic [7:0] OFS_HTOTAL = 8'h18;
  localparam logic [7:0] OFS_HDISPLAY_END = 8'h1c;
  localparam logic [7:0] OFS_HSYNC_START = 8'h20;
  localparam logic [7:0] OFS_HSYNC_END = 8'h24;
  localparam logic [7:0] OFS_MEMORY_CLOCK = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PC_HOLD_H = 1;
  localparam int PC_HOLD_V = 2;
  localparam int PC_SUSPEND = 3;
  localparam int PC_ACCESS_OFF = 4;
  localparam logic [7:0] PC_MASK = 8'h1e;
  localparam int MISC_HPOL = 6;
  localparam int MISC_VPOL = 7;
  localparam int MISC_CLKSEL_LO = 2;
  localparam int ST_SUSPEND = 0;
  localparam int ST_LOW_POWER = 1;
  localparam int ST_BLOCKED = 2;
  localparam int ST_DAC_DOWN = 3;
  localparam int ST_LEVEL_LO = 4;
  localparam int ST_SEQ_ERR = 6;
  localparam int ST_MCLK_LOW = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ****************************************************************
  // Low-power programming values recognised by the block
  // ****************************************************************
  localparam logic [7:0] LP_CLOCKING_MODE = 8'h29;
  localparam logic [1:0] LP_CLKSEL = 2'h0;
  localparam logic [15:0] LP_NUMERATOR = 16'h020f;
  localparam logic [7:0] LP_DENOMINATOR = 8'h3f;
  localparam logic [7:0] LP_VRETRACE_END = 8'h40;
  localparam logic [7:0] LP_HTOTAL = 8'h09;
  localparam logic [7:0] LP_HDISPLAY_END = 8'h02;
  localparam logic [7:0] LP_HSYNC_START = 8'h03;
  localparam logic [7:0] LP_HSYNC_END = 8'h02;
  localparam logic [7:0] LP_MEMORY_CLOCK = 8'h04;

  // ****************************************************************
  // Timing: 125 MHz reference, rates in kHz, times in ns
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_KHZ = 125000;
  localparam int VIDEO_LOW_KHZ = 3470;
  localparam int MEMORY_LOW_KHZ = 7140;
  localparam int RATE_MOD = CLK_KHZ / 10;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(RATE_MOD);
  localparam logic [ACC_W-1:0] STEP_FULL = ACC_W'(RATE_MOD);
  localparam logic [ACC_W-1:0] STEP_VIDEO_LOW = ACC_W'(VIDEO_LOW_KHZ / 10);
  localparam logic [ACC_W-1:0] STEP_MEMORY_LOW = ACC_W'(MEMORY_LOW_KHZ / 10);
  localparam int REFRESH_PERIOD_NS = 4600;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REFRESH_BURST = 5;
  localparam int RCNT_W = 10;
  localparam logic [RCNT_W-1:0] RCNT_LAST = RCNT_W'(REFRESH_PERIOD_CYC - 1);
  localparam logic [2:0] BURST_LEN = 3'(REFRESH_BURST);

  // ****************************************************************
  // Monitor power levels shown by the syncs
  // ****************************************************************
  typedef enum logic [1:0] {
    DPM_LVL_ON,
    DPM_LVL_STANDBY,
    DPM_LVL_SUSPEND,
    DPM_LVL_OFF
  } dpm_level_type;

endpackage

`default_nettype wire

// ==== rtl/dpm_rate_if.sv ====
`default_nettype none

// Rate request from the controller and tick back from the generator
interface dpm_rate_if;
  import dpm_pkg::*;
  logic run;
  logic [ACC_W-1:0] step;
  logic tick;
  modport ctrl (output run, output step, input tick);
  modport gen (input run, input step, output tick);
endinterface

`default_nettype wire

// ==== rtl/dpm_rate_gen.sv ====
`default_nettype none

// Fractional clock enable: tick rate is step over the modulus of the clock
module dpm_rate_gen (
  input wire logic ref_clk,
  input wire logic srst,
  dpm_rate_if.gen rate
);
  import dpm_pkg::*;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W:0] sum;
  logic tick_q;

  assign sum = {1'b0, acc_q} + {1'b0, rate.step};
  assign rate.tick = tick_q;

  // Accumulate; a stopped generator forgets its phase on purpose
  always_ff @(posedge ref_clk) begin
    if (srst || !rate.run) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else if (sum >= {1'b0, ACC_MOD}) begin
      acc_q <= ACC_W'(sum - {1'b0, ACC_MOD});
      tick_q <= 1'b1;
    end else begin
      acc_q <= sum[ACC_W-1:0];
      tick_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== rtl/dpm_top.sv ====
`default_nettype none

module dpm_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [dpm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dpm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic hsync_in,
  input wire logic vsync_in,
  output logic hsync_out,
  output logic vsync_out,
  output logic [1:0] dpms_level,
  output logic dac_power_down,
  output logic video_clk_en,
  output logic mem_clk_en,
  output logic dram_refresh,
  output logic screen_refresh_en,
  input wire logic host_mem_req,
  output logic host_mem_grant,
  input wire logic palette_req,
  output logic palette_grant
);
  import dpm_pkg::*;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] power_control_reg_q;
  logic [7:0] misc_output_reg_alias_q;
  logic [7:0] clocking_mode_reg_q;
  logic [15:0] clock_zero_numerator_reg_q;
  logic [7:0] clock_zero_denominator_reg_q;
  logic [7:0] vertical_retrace_end_reg_q;
  logic [7:0] horizontal_total_reg_q;
  logic [7:0] horizontal_display_end_reg_q;
  logic [7:0] horizontal_sync_start_reg_q;
  logic [7:0] horizontal_sync_end_reg_q;
  logic [7:0] memory_clock_reg_q;
  logic seq_err_q;
  logic [DATA_W-1:0] rdata_d;

  // ****************************************************************
  // Derived power state
  // ****************************************************************
  logic hold_h;
  logic hold_v;
  logic suspend;
  logic access_off;
  logic low_power;
  logic mclk_low;
  logic blocked;
  logic dac_down;
  dpm_level_type level;
  logic [7:0] status_byte;

  // ****************************************************************
  // Refresh pacing
  // ****************************************************************
  logic [RCNT_W-1:0] rcnt_q;
  logic [2:0] burst_q;

  // ****************************************************************
  // Clock enable generators
  // ****************************************************************
  dpm_rate_if video_rate ();
  dpm_rate_if memory_rate ();

  dpm_rate_gen u_video_rate (
    .ref_clk(ref_clk),
    .srst(srst),
    .rate(video_rate.gen)
  );

  dpm_rate_gen u_memory_rate (
    .ref_clk(ref_clk),
    .srst(srst),
    .rate(memory_rate.gen)
  );

  // Control bits pulled out of the power control register
  assign hold_h = power_control_reg_q[PC_HOLD_H];
  assign hold_v = power_control_reg_q[PC_HOLD_V];
  assign suspend = power_control_reg_q[PC_SUSPEND];
  assign access_off = power_control_reg_q[PC_ACCESS_OFF];

  // Low-power state is recognised from the programmed timing set, so a
  // host that writes any step differently simply stays in full operation
  assign low_power = (clocking_mode_reg_q == LP_CLOCKING_MODE) &&
    (misc_output_reg_alias_q[MISC_CLKSEL_LO +: 2] == LP_CLKSEL) &&
    (clock_zero_numerator_reg_q == LP_NUMERATOR) &&
    (clock_zero_denominator_reg_q == LP_DENOMINATOR) &&
    (vertical_retrace_end_reg_q == LP_VRETRACE_END) &&
    (horizontal_total_reg_q == LP_HTOTAL) &&
    (horizontal_display_end_reg_q == LP_HDISPLAY_END) &&
    (horizontal_sync_start_reg_q == LP_HSYNC_START) &&
    (horizontal_sync_end_reg_q == LP_HSYNC_END);

  // Reduced memory clock is independent of the other low-power steps
  assign mclk_low = (memory_clock_reg_q == LP_MEMORY_CLOCK);

  // Host memory path is closed by any of the three power-saving conditions
  assign blocked = suspend || access_off || low_power;

  // DAC off whenever a sync is frozen or the clocks are stopped
  assign dac_down = hold_h || hold_v || suspend;

  // Monitor level follows which syncs are frozen
  always_comb begin
    unique case ({hold_v, hold_h})
      2'b00: level = DPM_LVL_ON;
      2'b01: level = DPM_LVL_STANDBY;
      2'b10: level = DPM_LVL_SUSPEND;
      2'b11: level = DPM_LVL_OFF;
    endcase
  end

  // Video clock: stopped in suspend, slowed in low-power state
  assign video_rate.run = !suspend;
  assign video_rate.step = low_power ? STEP_VIDEO_LOW : STEP_FULL;

  // Memory clock: stopped in suspend, slowed when programmed low
  assign memory_rate.run = !suspend;
  assign memory_rate.step = mclk_low ? STEP_MEMORY_LOW : STEP_FULL;

  // ****************************************************************
  // Register writes
  // ****************************************************************

  // Power control; only the four documented bits are kept
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      power_control_reg_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == OFS_POWER_CONTROL) begin
      power_control_reg_q <= reg_wdata[7:0] & PC_MASK;
    end
  end

  // Sync polarity and clock select
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      misc_output_reg_alias_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == OFS_MISC_OUTPUT) begin
      misc_output_reg_alias_q <= reg_wdata[7:0];
    end
  end

  // Clock and timing set that defines the low-power state, plus the memory clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clocking_mode_reg_q <= RST_BYTE;
      clock_zero_numerator_reg_q <= RST_WORD;
      clock_zero_denominator_reg_q <= RST_BYTE;
      vertical_retrace_end_reg_q <= RST_BYTE;
      horizontal_total_reg_q <= RST_BYTE;
      horizontal_display_end_reg_q <= RST_BYTE;
      horizontal_sync_start_reg_q <= RST_BYTE;
      horizontal_sync_end_reg_q <= RST_BYTE;
      memory_clock_reg_q <= RST_BYTE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_CLOCKING_MODE: clocking_mode_reg_q <= reg_wdata[7:0];
        OFS_CLK0_NUMERATOR: clock_zero_numerator_reg_q <= reg_wdata;
        OFS_CLK0_DENOMINATOR: clock_zero_denominator_reg_q <= reg_wdata[7:0];
        OFS_VRETRACE_END: vertical_retrace_end_reg_q <= reg_wdata[7:0];
        OFS_HTOTAL: horizontal_total_reg_q <= reg_wdata[7:0];
        OFS_HDISPLAY_END: horizontal_display_end_reg_q <= reg_wdata[7:0];
        OFS_HSYNC_START: horizontal_sync_start_reg_q <= reg_wdata[7:0];
        OFS_HSYNC_END: horizontal_sync_end_reg_q <= reg_wdata[7:0];
        OFS_MEMORY_CLOCK: memory_clock_reg_q <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Ordering watchdog: suspend without access-disable is flagged.
  // Hardware set wins over a software write-one clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seq_err_q <= 1'b0;
    end else if (suspend && !access_off) begin
      seq_err_q <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_STATUS &&
                 reg_wdata[ST_SEQ_ERR]) begin
      seq_err_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************

  // Status gathers the live power state for software
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_SUSPEND] = suspend;
    status_byte[ST_LOW_POWER] = low_power;
    status_byte[ST_BLOCKED] = blocked;
    status_byte[ST_DAC_DOWN] = dac_down;
    status_byte[ST_LEVEL_LO +: 2] = level;
    status_byte[ST_SEQ_ERR] = seq_err_q;
    status_byte[ST_MCLK_LOW] = mclk_low;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = RST_WORD;
    unique case (reg_addr)
      OFS_POWER_CONTROL: rdata_d = {8'h00, power_control_reg_q};
      OFS_MISC_OUTPUT: rdata_d = {8'h00, misc_output_reg_alias_q};
      OFS_CLOCKING_MODE: rdata_d = {8'h00, clocking_mode_reg_q};
      OFS_CLK0_NUMERATOR: rdata_d = clock_zero_numerator_reg_q;
      OFS_CLK0_DENOMINATOR: rdata_d = {8'h00, clock_zero_denominator_reg_q};
      OFS_VRETRACE_END: rdata_d = {8'h00, vertical_retrace_end_reg_q};
      OFS_HTOTAL: rdata_d = {8'h00, horizontal_total_reg_q};
      OFS_HDISPLAY_END: rdata_d = {8'h00, horizontal_display_end_reg_q};
      OFS_HSYNC_START: rdata_d = {8'h00, horizontal_sync_start_reg_q};
      OFS_HSYNC_END: rdata_d = {8'h00, horizontal_sync_end_reg_q};
      OFS_MEMORY_CLOCK: rdata_d = {8'h00, memory_clock_reg_q};
      OFS_STATUS: rdata_d = {8'h00, status_byte};
      default: rdata_d = RST_WORD;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= RST_WORD;
    end
  end

  // ****************************************************************
  // Sync outputs toward the monitor
  // ****************************************************************

  // Frozen sync sits at its programmed polarity
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end else begin
      hsync_out <= hold_h ? misc_output_reg_alias_q[MISC_HPOL] : hsync_in;
      vsync_out <= hold_v ? misc_output_reg_alias_q[MISC_VPOL] : vsync_in;
    end
  end

  // Level and DAC state registered with the syncs so they move together
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dpms_level <= DPM_LVL_ON;
      dac_power_down <= 1'b0;
    end else begin
      dpms_level <= level;
      dac_power_down <= dac_down;
    end
  end

  // ****************************************************************
  // Clock enables and screen refresh
  // ****************************************************************

  // Enables come straight from the generators, which are held in suspend
  assign video_clk_en = video_rate.tick;
  assign mem_clk_en = memory_rate.tick;

  // Screen refresh stops with access-disable or suspend; oscillators
  // themselves keep running under access-disable alone
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      screen_refresh_en <= 1'b1;
    end else begin
      screen_refresh_en <= !(access_off || suspend);
    end
  end

  // ****************************************************************
  // DRAM refresh: five requests at the start of each 4.6 us window.
  // Runs on the reference clock so it survives suspend; this is the
  // slowest pace that still keeps memory, used in every state.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rcnt_q <= '0;
    end else if (rcnt_q == RCNT_LAST) begin
      rcnt_q <= '0;
    end else begin
      rcnt_q <= rcnt_q + RCNT_W'(1);
    end
  end

  // Burst counter loads at window start and drains one per cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      burst_q <= '0;
    end else if (rcnt_q == RCNT_LAST) begin
      burst_q <= BURST_LEN;
    end else if (burst_q != 3'h0) begin
      burst_q <= burst_q - 3'h1;
    end
  end

  assign dram_refresh = (burst_q != 3'h0);

  // ****************************************************************
  // Host access gates
  // ****************************************************************

  // Grants are combinational; memory requests in suspend, access-disable or low power are refused, palette only in suspend or low power
  assign host_mem_grant = host_mem_req && !blocked;
  assign palette_grant = palette_req && !(suspend || low_power);

endmodule

`default_nettype wire

// ==== verif/dpm_chk.sv ====
`default_nettype none

// ****************************************************************
// Power management checker
// ****************************************************************
module dpm_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [dpm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic [1:0] dpms_level,
  input wire logic dac_power_down,
  input wire logic video_clk_en,
  input wire logic mem_clk_en,
  input wire logic dram_refresh,
  input wire logic screen_refresh_en,
  input wire logic host_mem_grant,
  input wire logic palette_grant
);
  import dpm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pc_q;
  logic [7:0] misc_q;
  logic [9:0] gap_q;
  logic seen_q;
  logic refr_q;
  logic rise;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Shadow of the control registers, same write timing as the block
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_q <= 8'h00;
      misc_q <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_POWER_CONTROL) begin
      pc_q <= reg_wdata[7:0] & PC_MASK;
    end else if (reg_wr && reg_addr == OFS_MISC_OUTPUT) begin
      misc_q <= reg_wdata[7:0];
    end
  end
  assign rise = dram_refresh && !refr_q;
  // Cycles since the last burst began; saturates so it never wraps
  always_ff @(posedge ref_clk) begin
    refr_q <= srst ? 1'b0 : dram_refresh;
    seen_q <= srst ? 1'b0 : (seen_q || rise);
    if (srst || rise) begin
      gap_q <= 10'h000;
    end else if (gap_q != 10'h3ff) begin
      gap_q <= gap_q + 10'h001;
    end
  end
  a_hsync_hold: assert property (!$past(srst) |->
    hsync_out == ($past(pc_q[PC_HOLD_H]) ? $past(misc_q[MISC_HPOL])
    : $past(hsync_in))) else $error("hsync output wrong");
  a_vsync_hold: assert property (!$past(srst) |->
    vsync_out == ($past(pc_q[PC_HOLD_V]) ? $past(misc_q[MISC_VPOL])
    : $past(vsync_in))) else $error("vsync output wrong");
  a_level_code: assert property (!$past(srst) |->
    dpms_level == {$past(pc_q[PC_HOLD_V]), $past(pc_q[PC_HOLD_H])})
    else $error("power level code wrong");
  a_dac_down: assert property (!$past(srst) |->
    dac_power_down == $past(|(pc_q & 8'h0e))) else $error("dac state wrong");
  a_screen_gate: assert property (!$past(srst) |->
    screen_refresh_en == !$past(pc_q[PC_SUSPEND] | pc_q[PC_ACCESS_OFF]))
    else $error("screen refresh gate wrong");
  a_clk_gate: assert property (pc_q[PC_SUSPEND] [*4] |->
    !video_clk_en && !mem_clk_en) else $error("clock not gated");
  a_mem_block: assert property (pc_q[4:3] != 2'h0 |->
    !host_mem_grant) else $error("memory granted while blocked");
  a_pal_block: assert property (pc_q[PC_SUSPEND] |->
    !palette_grant) else $error("palette granted in suspend");
  a_burst_len: assert property ($rose(dram_refresh) |->
    dram_refresh [*5] ##1 !dram_refresh) else $error("refresh burst length");
  a_burst_gap: assert property ($rose(dram_refresh) && seen_q |->
    gap_q == 10'(REFRESH_PERIOD_CYC - 1)) else $error("refresh period wrong");
  a_reset_state: assert property ($fell(srst) |-> dpms_level == 2'h0 &&
    !dac_power_down && screen_refresh_en) else $error("reset state wrong");
  c_off: cover property (dpms_level == 2'h3);
  c_suspend: cover property (pc_q[4:3] == 2'h3);
  c_burst: cover property ($rose(dram_refresh) && seen_q);
endmodule

bind dpm_top dpm_chk dpm_chk_inst (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .hsync_in(hsync_in),
  .vsync_in(vsync_in), .hsync_out(hsync_out), .vsync_out(vsync_out),
  .dpms_level(dpms_level), .dac_power_down(dac_power_down),
  .video_clk_en(video_clk_en), .mem_clk_en(mem_clk_en),
  .dram_refresh(dram_refresh), .screen_refresh_en(screen_refresh_en),
  .host_mem_grant(host_mem_grant), .palette_grant(palette_grant)
);

`default_nettype wire

// ==== verif/dpm_monitor.sv ====
`default_nettype none

// Display that decodes its power level from sync activity
module dpm_monitor #(
  parameter int IDLE_CYC = 24
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsync,
  input wire logic vsync,
  output logic [1:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic h_q;
  logic v_q;
  int h_idle;
  int v_idle;
  // A sync that stops toggling counts as idle; no polarity is assumed
  always_ff @(posedge ref_clk) begin
    h_q <= hsync;
    v_q <= vsync;
    h_idle <= (srst || hsync != h_q) ? 0 : h_idle + 1;
    v_idle <= (srst || vsync != v_q) ? 0 : v_idle + 1;
  end
  // Standby is horizontal idle, suspend vertical idle, off both
  assign level = {v_idle >= IDLE_CYC, h_idle >= IDLE_CYC};
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpm_pkg::*;
  logic ref_clk = 1'b0;
  logic srst, reg_wr, reg_rd, hsync_in, vsync_in;
  logic host_mem_req, palette_req;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic hsync_out, vsync_out, dac_power_down, video_clk_en, mem_clk_en;
  logic dram_refresh, screen_refresh_en, host_mem_grant, palette_grant;
  logic [1:0] dpms_level, mon_level;
  logic [7:0] ph_q = 8'h00;
  int n_fail = 0;
  int total_checks = 0;
  int cnt_v, cnt_m, cnt_r;
  logic [23:0] lp_tab [10] = '{{OFS_CLOCKING_MODE, 16'h0029},
    {OFS_MISC_OUTPUT, 16'h0000}, {OFS_CLK0_NUMERATOR, 16'h020f},
    {OFS_CLK0_DENOMINATOR, 16'h003f}, {OFS_VRETRACE_END, 16'h0040},
    {OFS_HTOTAL, 16'h0009}, {OFS_HDISPLAY_END, 16'h0002},
    {OFS_HSYNC_START, 16'h0003}, {OFS_HSYNC_END, 16'h0002},
    {OFS_MEMORY_CLOCK, 16'h0004}};

  dpm_top dpm_top_inst (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
    .vsync_in(vsync_in), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .dpms_level(dpms_level), .dac_power_down(dac_power_down),
    .video_clk_en(video_clk_en), .mem_clk_en(mem_clk_en),
    .dram_refresh(dram_refresh), .screen_refresh_en(screen_refresh_en),
    .host_mem_req(host_mem_req), .host_mem_grant(host_mem_grant),
    .palette_req(palette_req), .palette_grant(palette_grant));
  dpm_monitor dpm_monitor_inst (.ref_clk(ref_clk), .srst(srst),
    .hsync(hsync_out), .vsync(vsync_out), .level(mon_level));

  // ****************************************************************
  // Clock and raw syncs
  // ****************************************************************
  always #4 ref_clk = ~ref_clk;
  // Free-running syncs so a held output is told apart from a live one
  always @(posedge ref_clk) begin
    ph_q <= ph_q + 8'h01;
    hsync_in <= ph_q[1];
    vsync_in <= ph_q[3];
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] m,
      input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Sampled on the falling edge, well clear of the enable flops
  task automatic count(input int n);
    cnt_v = 0;
    cnt_m = 0;
    cnt_r = 0;
    repeat (n) begin
      @(negedge ref_clk);
      cnt_v += video_clk_en;
      cnt_m += mem_clk_en;
      cnt_r += dram_refresh;
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {srst, reg_wr, reg_rd} = 3'b100;
    {host_mem_req, palette_req, reg_addr, reg_wdata} = 26'h3000000;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    idle(40);
    chk({dpms_level, screen_refresh_en, dac_power_down}, 4'h2);
    chk(mon_level, 2'h0);
    rd(OFS_POWER_CONTROL, 16'hffff, 16'h0000);
    rd(8'h30, 16'hffff, 16'h0000);
    // Each level, held polarity 0 when one sync is frozen and 1 when both are
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MISC_OUTPUT, {8'h00, i[0], i[1], 6'h00});
      wr(OFS_POWER_CONTROL, 16'(i << 1));
      idle(40);
      chk(dpms_level, i);
      chk(mon_level, i);
      chk(dac_power_down, i != 0);
      if (i[0]) chk(hsync_out, i[1]);
      if (i[1]) chk(vsync_out, i[0]);
    end
    wr(OFS_POWER_CONTROL, 16'h0000);
    wr(OFS_POWER_CONTROL, 16'h0010);
    idle(4);
    chk({host_mem_grant, palette_grant, screen_refresh_en}, 3'h2);
    count(10);
    chk(cnt_v, 10);
    wr(OFS_POWER_CONTROL, 16'h0018);
    idle(4);
    count(1150);
    chk(cnt_v + cnt_m, 0);
    chk(cnt_r, 10);
    chk({palette_grant, host_mem_grant, dac_power_down}, 3'h1);
    rd(OFS_STATUS, 16'h0040, 16'h0000);
    wr(OFS_POWER_CONTROL, 16'h0010);
    wr(OFS_POWER_CONTROL, 16'h0000);
    // Suspend without access-disable first is flagged, then cleared
    wr(OFS_POWER_CONTROL, 16'h0008);
    rd(OFS_STATUS, 16'h0040, 16'h0040);
    wr(OFS_POWER_CONTROL, 16'h0000);
    wr(OFS_STATUS, 16'h0040);
    rd(OFS_STATUS, 16'h0040, 16'h0000);
    foreach (lp_tab[k]) wr(lp_tab[k][23:16], lp_tab[k][15:0]);
    idle(4);
    chk({host_mem_grant, palette_grant, screen_refresh_en}, 3'h1);
    count(12500);
    chk(cnt_v, 347);
    chk(cnt_m, 714);
    wr(OFS_HTOTAL, 16'h005f);
    idle(4);
    chk({host_mem_grant, palette_grant}, 2'h3);
    complete_run();
  end

  // Whole run is near 14000 cycles; about twice that means a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
endmodule

`default_nettype wire
